/* File: core/always_on_domain_supervisor_regs.sv */
// key-protected registers of the always-on supervisor, apb slave
//
// Notes on behaviour
// [RULE1] debug freeze bit blocks debug code writes
// [RULE2] debug code 0x5 enables debug, sets flag
// [RULE3] keep core domain on in hibernate
// [RULE4] bandgap low power in deepsleep, resets one
// [RULE5] thermal monitor enable bit, resets zero
// [RULE6] hardware sets core and io brownout flags
// [RULE7] writing clear bit clears that flag
// [RULE8] response bit: one interrupt, zero hard reset
// [RULE9] brownout freeze locks responses and levels
// [RULE10] three-bit levels, defaults five and four
// [RULE11] filter width codes select 16 to 128us
// [RULE12] core rise width resets three, others zero
// [RULE13] separate filter enables, reset zero
// [RULE14] deglitch and clock writes need config key
// [RULE15] clock select: zero slow, one fast
// [RULE16] status bits mirror both oscillators
// [RULE17] eight-bit slow oscillator trim field
// [RULE18] scan code 0x1c unlocks scan, sets flag
// [RULE19] launch enters test mode until power cycle
// [RULE20] scan freeze bit blocks scan code writes
// [RULE21] scan flag reads unlock state
// [RULE22] config code 0xb grants protected writes
// [RULE23] clear bits self-clear, detection wins
// [RULE24] freeze bits cleared only by reset
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module always_on_domain_supervisor_regs #(
  parameter int unsigned FILTER_UNIT_CYCLES =
    aon_supervisor_pkg::FILTER_UNIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_brownout_raw,
  input wire logic io_brownout_raw,
  input wire logic fast_osc_enabled,
  input wire logic slow_osc_in_use,
  output aon_supervisor_pkg::supervisor_out_t supervisor_out
);

  typedef struct packed {
    aon_supervisor_pkg::config_unlock_t unlock;
    aon_supervisor_pkg::power_debug_control_t power;
    aon_supervisor_pkg::brownout_config_t brown;
    aon_supervisor_pkg::brownout_deglitch_t dgl;
    aon_supervisor_pkg::always_on_clock_control_t clock;
    aon_supervisor_pkg::scan_test_entry_t scan;
    logic scan_mode;
    logic core_prev;
    logic io_prev;
    logic irq;
    logic hard_reset;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  localparam state_t ST_RST = '{
    power: '{deepsleep_bandgap_low_power: aon_supervisor_pkg::BANDGAP_LP_RST,
             default: '0}, // see [RULE4]
    brown: '{core_brownout_level: aon_supervisor_pkg::CORE_LEVEL_RST,
             io_brownout_level: aon_supervisor_pkg::IO_LEVEL_RST,
             default: '0}, // see [RULE10]
    dgl: '{core_rise_filter_width: aon_supervisor_pkg::CORE_RISE_WIDTH_RST,
           default: '0}, // see [RULE12]
    clock: '{slow_osc_trim: aon_supervisor_pkg::SLOW_TRIM_RST, default: '0},
    default: '0
  };

  state_t st_q;
  state_t st_d;
  logic core_filtered;
  logic io_filtered;
  logic core_event;
  logic io_event;
  logic setup_phase;
  logic wr_access;
  aon_supervisor_pkg::filter_setup_t core_setup;
  aon_supervisor_pkg::filter_setup_t io_setup;
  aon_supervisor_pkg::config_unlock_t w_unlock;
  aon_supervisor_pkg::power_debug_control_t w_power;
  aon_supervisor_pkg::brownout_config_t w_brown;
  aon_supervisor_pkg::brownout_deglitch_t w_dgl;
  aon_supervisor_pkg::always_on_clock_control_t w_clock;
  aon_supervisor_pkg::scan_test_entry_t w_scan;

  ////////////////////////////////////////////////////////////////////////////
  // brownout deglitch filters
  assign core_setup = '{enable: st_q.dgl.core_filter_enable,
                        rise_width: st_q.dgl.core_rise_filter_width,
                        fall_width: st_q.dgl.core_fall_filter_width};
  assign io_setup = '{enable: st_q.dgl.io_filter_enable,
                      rise_width: st_q.dgl.io_rise_filter_width,
                      fall_width: st_q.dgl.io_fall_filter_width};

  brownout_filter #(
    .UNIT_CYCLES(FILTER_UNIT_CYCLES),
    .CNT_W(aon_supervisor_pkg::FILTER_CNT_W)
  ) u_core_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw_level(core_brownout_raw),
    .setup(core_setup),
    .filtered_level(core_filtered)
  );

  brownout_filter #(
    .UNIT_CYCLES(FILTER_UNIT_CYCLES),
    .CNT_W(aon_supervisor_pkg::FILTER_CNT_W)
  ) u_io_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw_level(io_brownout_raw),
    .setup(io_setup),
    .filtered_level(io_filtered)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and register update
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & st_q.pready & pwrite;
  assign core_event = core_filtered & ~st_q.core_prev;
  assign io_event = io_filtered & ~st_q.io_prev;
  assign w_unlock = pwdata;
  assign w_power = pwdata;
  assign w_brown = pwdata;
  assign w_dgl = pwdata;
  assign w_clock = pwdata;
  assign w_scan = pwdata;

  always_comb begin
    st_d = st_q;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    st_d.brown.core_brownout_flag_clear = 1'b0; // see [RULE23]
    st_d.brown.io_brownout_flag_clear = 1'b0; // see [RULE23]
    // read data is captured in the setup cycle, answered one cycle later
    if (setup_phase) begin
      st_d.pready = 1'b1;
      st_d.prdata = '0;
      unique case (paddr)
        aon_supervisor_pkg::ADDR_CONFIG_UNLOCK: st_d.prdata = st_q.unlock;
        aon_supervisor_pkg::ADDR_POWER_DEBUG: st_d.prdata = st_q.power;
        aon_supervisor_pkg::ADDR_BROWNOUT_CONFIG: st_d.prdata = st_q.brown;
        aon_supervisor_pkg::ADDR_BROWNOUT_DEGLITCH: st_d.prdata = st_q.dgl;
        aon_supervisor_pkg::ADDR_CLOCK_CONTROL: begin
          st_d.prdata = st_q.clock;
          st_d.prdata[17] = fast_osc_enabled; // see [RULE16]
          st_d.prdata[16] = slow_osc_in_use; // see [RULE16]
        end
        aon_supervisor_pkg::ADDR_SCAN_ENTRY: st_d.prdata = st_q.scan;
        default: st_d.pslverr = 1'b1;
      endcase
    end
    if (wr_access) begin
      unique case (paddr)
        aon_supervisor_pkg::ADDR_CONFIG_UNLOCK: begin
          if (w_unlock.config_key_freeze) begin
            st_d.unlock.config_key_freeze = 1'b1; // see [RULE24]
          end
          if (!st_q.unlock.config_key_freeze) begin
            st_d.unlock.config_unlock_code = w_unlock.config_unlock_code;
            st_d.unlock.config_unlocked_flag = (w_unlock.config_unlock_code
              == aon_supervisor_pkg::CONFIG_KEY); // see [RULE22]
          end
        end
        aon_supervisor_pkg::ADDR_POWER_DEBUG: begin
          if (w_power.debug_key_freeze) begin
            st_d.power.debug_key_freeze = 1'b1; // see [RULE24]
          end
          if (!st_q.power.debug_key_freeze) begin // see [RULE1]
            st_d.power.debug_unlock_code = w_power.debug_unlock_code;
            st_d.power.debug_unlocked_flag = (w_power.debug_unlock_code
              == aon_supervisor_pkg::DEBUG_KEY); // see [RULE2]
          end
          st_d.power.thermal_monitor_enable =
            w_power.thermal_monitor_enable; // see [RULE5]
          st_d.power.deepsleep_bandgap_low_power =
            w_power.deepsleep_bandgap_low_power; // see [RULE4]
          st_d.power.core_domain_keep_on_sleep =
            w_power.core_domain_keep_on_sleep; // see [RULE3]
        end
        aon_supervisor_pkg::ADDR_BROWNOUT_CONFIG: begin
          st_d.brown.core_brownout_flag_clear =
            w_brown.core_brownout_flag_clear; // see [RULE7]
          st_d.brown.io_brownout_flag_clear =
            w_brown.io_brownout_flag_clear; // see [RULE7]
          if (w_brown.brownout_freeze) begin
            st_d.brown.brownout_freeze = 1'b1; // see [RULE24]
          end
          if (!st_q.brown.brownout_freeze) begin // see [RULE9]
            st_d.brown.core_brownout_response =
              w_brown.core_brownout_response;
            st_d.brown.io_brownout_response = w_brown.io_brownout_response;
            st_d.brown.core_brownout_level =
              w_brown.core_brownout_level; // see [RULE10]
            st_d.brown.io_brownout_level = w_brown.io_brownout_level;
          end
        end
        aon_supervisor_pkg::ADDR_BROWNOUT_DEGLITCH: begin
          if (st_q.unlock.config_unlocked_flag) begin // see [RULE14]
            st_d.dgl.io_rise_filter_width = w_dgl.io_rise_filter_width;
            st_d.dgl.io_fall_filter_width = w_dgl.io_fall_filter_width;
            st_d.dgl.io_filter_enable = w_dgl.io_filter_enable;
            st_d.dgl.core_rise_filter_width = w_dgl.core_rise_filter_width;
            st_d.dgl.core_fall_filter_width = w_dgl.core_fall_filter_width;
            st_d.dgl.core_filter_enable = w_dgl.core_filter_enable;
          end
        end
        aon_supervisor_pkg::ADDR_CLOCK_CONTROL: begin
          if (st_q.unlock.config_unlocked_flag) begin // see [RULE14]
            st_d.clock.slow_osc_trim = w_clock.slow_osc_trim; // see [RULE17]
            st_d.clock.slow_osc_high_bw = w_clock.slow_osc_high_bw;
            st_d.clock.always_on_clock_select =
              w_clock.always_on_clock_select; // see [RULE15]
          end
        end
        aon_supervisor_pkg::ADDR_SCAN_ENTRY: begin
          if (w_scan.scan_code_freeze) begin
            st_d.scan.scan_code_freeze = 1'b1; // see [RULE24]
          end
          if (!st_q.scan.scan_code_freeze) begin // see [RULE20]
            st_d.scan.scan_unlocked_flag = (w_scan.scan_unlock_code
              == aon_supervisor_pkg::SCAN_KEY); // see [RULE18] [RULE21]
          end
          if (w_scan.scan_mode_launch && st_q.scan.scan_unlocked_flag) begin
            st_d.scan_mode = 1'b1; // see [RULE19]
          end
        end
        default: ;
      endcase
    end
    // detection sets, a pending clear acts one cycle after the write
    st_d.core_prev = core_filtered;
    st_d.io_prev = io_filtered;
    st_d.brown.core_brownout_flag = core_event | (st_q.brown.core_brownout_flag
      & ~st_q.brown.core_brownout_flag_clear); // see [RULE6] [RULE23]
    st_d.brown.io_brownout_flag = io_event | (st_q.brown.io_brownout_flag
      & ~st_q.brown.io_brownout_flag_clear); // see [RULE6] [RULE23]
    st_d.irq = (st_d.brown.core_brownout_flag
                & st_q.brown.core_brownout_response)
             | (st_d.brown.io_brownout_flag
                & st_q.brown.io_brownout_response); // see [RULE8]
    st_d.hard_reset = (core_event & ~st_q.brown.core_brownout_response)
                    | (io_event & ~st_q.brown.io_brownout_response);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all taken from state flops
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign supervisor_out = '{
    debug_enable: st_q.power.debug_unlocked_flag,
    core_domain_keep_on_sleep: st_q.power.core_domain_keep_on_sleep,
    deepsleep_bandgap_low_power: st_q.power.deepsleep_bandgap_low_power,
    thermal_monitor_enable: st_q.power.thermal_monitor_enable,
    core_brownout_level: st_q.brown.core_brownout_level,
    io_brownout_level: st_q.brown.io_brownout_level,
    always_on_clock_select: st_q.clock.always_on_clock_select,
    slow_osc_trim: st_q.clock.slow_osc_trim,
    slow_osc_high_bw: st_q.clock.slow_osc_high_bw,
    scan_mode_active: st_q.scan_mode,
    peripheral_access_cut: st_q.scan_mode,
    brownout_irq: st_q.irq,
    brownout_hard_reset: st_q.hard_reset
  };

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence power_write_s;
    wr_access && paddr == aon_supervisor_pkg::ADDR_POWER_DEBUG;
  endsequence

  sequence core_clear_s;
    wr_access && paddr == aon_supervisor_pkg::ADDR_BROWNOUT_CONFIG
      && w_brown.core_brownout_flag_clear ##1 !core_event;
  endsequence

  AST_DEBUG_FREEZE_HOLDS: assert property ( // see [RULE1]
    power_write_s and st_q.power.debug_key_freeze
      |=> $stable(st_q.power.debug_unlock_code))
    else $error("debug code changed while frozen");

  AST_DEBUG_KEY_ENABLES: assert property ( // see [RULE2]
    power_write_s and !st_q.power.debug_key_freeze
      |=> supervisor_out.debug_enable ==
          ($past(w_power.debug_unlock_code) == aon_supervisor_pkg::DEBUG_KEY))
    else $error("debug enable does not follow the key");

  AST_THERMAL_ENABLE: assert property ( // see [RULE5]
    power_write_s |=> supervisor_out.thermal_monitor_enable
      == $past(w_power.thermal_monitor_enable))
    else $error("thermal enable not updated");

  AST_FLAG_ON_EVENT: assert property ( // see [RULE6]
    core_event |=> st_q.brown.core_brownout_flag [*2])
    else $error("core brownout flag not set by detection");

  AST_FLAG_CLEARED: assert property ( // see [RULE7]
    core_clear_s |=> !st_q.brown.core_brownout_flag)
    else $error("core brownout flag not cleared");

  AST_HARD_RESET_ACTION: assert property ( // see [RULE8]
    core_event && !st_q.brown.core_brownout_response
      |=> supervisor_out.brownout_hard_reset ##1 !supervisor_out.brownout_irq
          || st_q.brown.io_brownout_flag)
    else $error("brownout response not honoured");

  AST_BROWNOUT_FREEZE: assert property ( // see [RULE9]
    wr_access && paddr == aon_supervisor_pkg::ADDR_BROWNOUT_CONFIG
      && st_q.brown.brownout_freeze
      |=> $stable(st_q.brown.core_brownout_level)
          && $stable(st_q.brown.io_brownout_response))
    else $error("frozen brownout setting changed");

  AST_DEGLITCH_GATED: assert property ( // see [RULE14]
    wr_access && paddr == aon_supervisor_pkg::ADDR_BROWNOUT_DEGLITCH
      && !st_q.unlock.config_unlocked_flag |=> $stable(st_q.dgl))
    else $error("deglitch written without config key");

  AST_SCAN_MODE_STICKY: assert property ( // see [RULE19]
    supervisor_out.scan_mode_active |=> supervisor_out.scan_mode_active [*3])
    else $error("scan mode left without reset");

  AST_FREEZE_STICKY: assert property ( // see [RULE24]
    st_q.scan.scan_code_freeze && st_q.power.debug_key_freeze
      |=> st_q.scan.scan_code_freeze && st_q.power.debug_key_freeze)
    else $error("freeze bit dropped");

  AST_PREADY_ONE_CYCLE: assert property (
    setup_phase |=> pready ##1 !pready)
    else $error("pready timing wrong");

endmodule // always_on_domain_supervisor_regs

/* File: shared/aon_supervisor_pkg.sv */
// constants, register layouts and carrier types of the always-on supervisor
package aon_supervisor_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [31:0] ADDR_CONFIG_UNLOCK = 32'h50015004;
  localparam logic [31:0] ADDR_POWER_DEBUG = 32'h50015018;
  localparam logic [31:0] ADDR_BROWNOUT_CONFIG = 32'h5001501c;
  localparam logic [31:0] ADDR_BROWNOUT_DEGLITCH = 32'h50015020;
  localparam logic [31:0] ADDR_CLOCK_CONTROL = 32'h50015024;
  localparam logic [31:0] ADDR_SCAN_ENTRY = 32'h50015028;

  ////////////////////////////////////////////////////////////////////////////
  // unlock codes and reset values
  localparam logic [3:0] DEBUG_KEY = 4'h5;
  localparam logic [3:0] CONFIG_KEY = 4'hb;
  localparam logic [7:0] SCAN_KEY = 8'h1c;
  localparam logic BANDGAP_LP_RST = 1'b1;
  localparam logic [2:0] CORE_LEVEL_RST = 3'h5;
  localparam logic [2:0] IO_LEVEL_RST = 3'h4;
  localparam logic [1:0] CORE_RISE_WIDTH_RST = 2'h3;
  // trim powers up undefined; a plain zero is used here
  localparam logic [7:0] SLOW_TRIM_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing: the shortest filter width, doubled for each code step
  localparam int unsigned FILTER_UNIT_US = 16;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned FILTER_UNIT_CYCLES = FILTER_UNIT_US * CLK_MHZ;
  localparam int unsigned FILTER_CNT_W = 15;

  ////////////////////////////////////////////////////////////////////////////
  // register layouts, msb first
  typedef struct packed {
    logic config_key_freeze;
    logic [25:0] rsv_a;
    logic config_unlocked_flag;
    logic [3:0] config_unlock_code;
  } config_unlock_t;

  typedef struct packed {
    logic debug_key_freeze;
    logic debug_unlocked_flag;
    logic [3:0] debug_unlock_code;
    logic [11:0] rsv_a;
    logic thermal_monitor_enable;
    logic [10:0] rsv_b;
    logic deepsleep_bandgap_low_power;
    logic core_domain_keep_on_sleep;
  } power_debug_control_t;

  typedef struct packed {
    logic [15:0] rsv_a;
    logic core_brownout_flag_clear;
    logic io_brownout_flag_clear;
    logic core_brownout_flag;
    logic io_brownout_flag;
    logic rsv_b;
    logic brownout_freeze;
    logic core_brownout_response;
    logic io_brownout_response;
    logic rsv_c;
    logic [2:0] core_brownout_level;
    logic rsv_d;
    logic [2:0] io_brownout_level;
  } brownout_config_t;

  typedef struct packed {
    logic [15:0] rsv_a;
    logic [1:0] io_rise_filter_width;
    logic [1:0] io_fall_filter_width;
    logic [2:0] rsv_b;
    logic io_filter_enable;
    logic [1:0] core_rise_filter_width;
    logic [1:0] core_fall_filter_width;
    logic [2:0] rsv_c;
    logic core_filter_enable;
  } brownout_deglitch_t;

  typedef struct packed {
    logic [13:0] rsv_a;
    logic fast_osc_running;
    logic slow_osc_selected;
    logic [7:0] slow_osc_trim;
    logic [2:0] rsv_b;
    logic slow_osc_high_bw;
    logic [2:0] rsv_c;
    logic always_on_clock_select;
  } always_on_clock_control_t;

  typedef struct packed {
    logic [19:0] rsv_a;
    logic scan_mode_launch;
    logic scan_unlocked_flag;
    logic scan_code_freeze;
    logic rsv_b;
    logic [7:0] scan_unlock_code;
  } scan_test_entry_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic enable;
    logic [1:0] rise_width;
    logic [1:0] fall_width;
  } filter_setup_t;

  typedef struct packed {
    logic debug_enable;
    logic core_domain_keep_on_sleep;
    logic deepsleep_bandgap_low_power;
    logic thermal_monitor_enable;
    logic [2:0] core_brownout_level;
    logic [2:0] io_brownout_level;
    logic always_on_clock_select;
    logic [7:0] slow_osc_trim;
    logic slow_osc_high_bw;
    logic scan_mode_active;
    logic peripheral_access_cut;
    logic brownout_irq;
    logic brownout_hard_reset;
  } supervisor_out_t;

endpackage

/* File: core/brownout_filter.sv */
// deglitch filter for one brownout detector level
`timescale 1ns/1ps
module brownout_filter #(
  parameter int unsigned UNIT_CYCLES = aon_supervisor_pkg::FILTER_UNIT_CYCLES,
  parameter int unsigned CNT_W = aon_supervisor_pkg::FILTER_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw_level,
  input wire aon_supervisor_pkg::filter_setup_t setup,
  output logic filtered_level
);

  typedef struct packed {
    logic level;
    logic [CNT_W-1:0] cnt;
  } filter_state_t;

  localparam logic [CNT_W-1:0] UNIT = CNT_W'(UNIT_CYCLES);

  filter_state_t st_q;
  filter_state_t st_d;
  logic [CNT_W-1:0] limit;

  assign filtered_level = st_q.level;

  ////////////////////////////////////////////////////////////////////////////
  // a change must persist for the selected width before it passes
  always_comb begin
    st_d = st_q;
    limit = raw_level ? (UNIT << setup.rise_width)
                      : (UNIT << setup.fall_width); // see [RULE11]
    if (!setup.enable) begin // see [RULE13]
      st_d.level = raw_level;
      st_d.cnt = '0;
    end else if (raw_level == st_q.level) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= limit - 1'b1) begin
      st_d.level = raw_level;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule // brownout_filter

/* File: verif/test_always_on_domain_supervisor_regs.sv */
// self-checking bench for the always-on supervisor register bank
`timescale 1ns/1ps
module test_always_on_domain_supervisor_regs;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic core_raw, io_raw, fast_on, slow_on, err;
  aon_supervisor_pkg::supervisor_out_t sout;
  int bad_count, compares, hr_count;
  localparam logic [31:0] A_UNL = aon_supervisor_pkg::ADDR_CONFIG_UNLOCK;
  localparam logic [31:0] A_PWR = aon_supervisor_pkg::ADDR_POWER_DEBUG;
  localparam logic [31:0] A_BO = aon_supervisor_pkg::ADDR_BROWNOUT_CONFIG;
  localparam logic [31:0] A_DG = aon_supervisor_pkg::ADDR_BROWNOUT_DEGLITCH;
  localparam logic [31:0] A_CLK = aon_supervisor_pkg::ADDR_CLOCK_CONTROL;
  localparam logic [31:0] A_SCAN = aon_supervisor_pkg::ADDR_SCAN_ENTRY;

  always_on_domain_supervisor_regs #(.FILTER_UNIT_CYCLES(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_brownout_raw(core_raw),
    .io_brownout_raw(io_raw), .fast_osc_enabled(fast_on),
    .slow_osc_in_use(slow_on), .supervisor_out(sout));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // counts hard reset pulses seen on the output
  always @(posedge pclk) begin
    if (sout.brownout_hard_reset === 1'b1) hr_count++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; answer taken at the rising edge where pready is high
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(penable === 1'b1 && pready === 1'b1) && n < 20);
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(string nm, logic [31:0] a, logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    rchk("pwr_dbg", A_PWR, 32'h2);
    chk("bg", {31'h0, sout.deepsleep_bandgap_low_power}, 32'h1);
    rchk("bo_cfg", A_BO, 32'h54);
    rchk("deglitch", A_DG, 32'hc0);
    rchk("clk_rst", A_CLK, 32'h20000);
    rchk("scan", A_SCAN, 32'h0);
    xfer(1'b0, 32'h50015000, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
  endtask

  task automatic debug_key();
    xfer(1'b1, A_PWR, 32'h0c002001);
    rchk("dbg_bad", A_PWR, 32'h0c002001);
    chk("thermal", {31'h0, sout.thermal_monitor_enable}, 32'h1);
    chk("keep", {31'h0, sout.core_domain_keep_on_sleep}, 32'h1);
    xfer(1'b1, A_PWR, 32'h94000000);
    xfer(1'b1, A_PWR, 32'h0);
    rchk("dbg_frz", A_PWR, 32'hd4000000);
    chk("dbg_en", {31'h0, sout.debug_enable}, 32'h1);
  endtask

  task automatic config_gate();
    xfer(1'b1, A_DG, 32'h4111);
    rchk("dg_nokey", A_DG, 32'hc0);
    xfer(1'b1, A_UNL, 32'hb);
    rchk("cfg_key", A_UNL, 32'h1b);
    xfer(1'b1, A_DG, 32'h4111);
    rchk("dg_key", A_DG, 32'h4111);
    xfer(1'b1, A_CLK, 32'ha511);
    rchk("clk", A_CLK, 32'h2a511);
    chk("sel", {31'h0, sout.always_on_clock_select}, 32'h1);
    chk("trim", {24'h0, sout.slow_osc_trim}, 32'ha5);
    chk("high_bw", {31'h0, sout.slow_osc_high_bw}, 32'h1);
    // any other key value revokes protected write access
    xfer(1'b1, A_UNL, 32'h3);
    xfer(1'b1, A_CLK, 32'h0);
    rchk("clk_nokey", A_CLK, 32'h2a511);
  endtask

  task automatic brownout();
    xfer(1'b1, A_BO, 32'h554);
    xfer(1'b1, A_BO, 32'h372);
    rchk("bo_frz", A_BO, 32'h554);
    chk("core_lvl", {29'h0, sout.core_brownout_level}, 32'h5);
    // a glitch shorter than the 8-cycle io rise width must be filtered
    @(posedge pclk) io_raw <= 1'b1;
    repeat (2) @(posedge pclk);
    io_raw <= 1'b0;
    repeat (20) @(posedge pclk);
    rchk("bo_glitch", A_BO, 32'h554);
    hr_count = 0;
    core_raw <= 1'b1;
    io_raw <= 1'b1;
    repeat (30) @(posedge pclk);
    rchk("bo_flags", A_BO, 32'h3554);
    chk("hard_rst", hr_count, 32'h1);
    chk("irq", {31'h0, sout.brownout_irq}, 32'h1);
    xfer(1'b1, A_BO, 32'hc554);
    rchk("bo_clr", A_BO, 32'h554);
    chk("irq_clr", {31'h0, sout.brownout_irq}, 32'h0);
  endtask

  task automatic scan_entry();
    xfer(1'b1, A_SCAN, 32'h1c);
    rchk("scan_flag", A_SCAN, 32'h400);
    xfer(1'b1, A_SCAN, 32'h21c);
    xfer(1'b1, A_SCAN, 32'h0);
    rchk("scan_frz", A_SCAN, 32'h600);
    xfer(1'b1, A_SCAN, 32'h800);
    // the launch lands at the closing edge; look one edge later
    @(posedge pclk);
    chk("scan_on", {31'h0, sout.scan_mode_active}, 32'h1);
    chk("cut", {31'h0, sout.peripheral_access_cut}, 32'h1);
    repeat (5) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    core_raw = 1'b0;
    io_raw = 1'b0;
    fast_on = 1'b1;
    slow_on = 1'b0;
    bad_count = 0;
    compares = 0;
    hr_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    debug_key();
    config_gate();
    brownout();
    scan_entry();
    finish_test();
  end
endmodule // test_always_on_domain_supervisor_regs
